// file: src_pkg.sv
// Function
// - Accept nine sources: power-on, pin, instruction, watchdog, brownout, mismatch, trap, opcode, wreg.
// - Master system reset is active while any reset source is active.
// - Each reset sets the status bit naming its own cause.
// - Power-on clears all status bits, then sets brownout and power-on bits 1:0.
// - Software may set or clear any status bit, except while power-on is active.
// - Writing a status bit only changes the flag, never causes a reset.
// - Undefined registers are unknown at power-on, kept through other resets.
package src_pkg;
    localparam int NSRC = 9;
    // Cause bit positions in the status word
    localparam int BIT_POR = 0;
    localparam int BIT_BROWN = 1;
    localparam int BIT_PIN = 2;
    localparam int BIT_INSTR = 3;
    localparam int BIT_WDOG = 4;
    localparam int BIT_CFG = 5;
    localparam int BIT_TRAP = 6;
    localparam int BIT_IOP = 7;
    localparam int BIT_WREG = 8;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_SCRATCH = 12'h004;
    localparam logic [8:0] STATUS_POR_VAL = 9'h003;
    localparam logic [8:0] STATUS_MASK = 9'h1ff;
    localparam logic [31:0] SCRATCH_RST = 32'h00000000;
    localparam int SYNC_STAGES = 2;
endpackage

// file: src_bus_if.sv
`timescale 1ns/1ns
interface src_bus_if;
    logic [8:0] srcRaw;
    logic [8:0] srcSync;
    modport sync (input srcRaw, output srcSync);
    modport core (output srcRaw, input srcSync);
endinterface

// file: src_sync.sv
`timescale 1ns/1ns
module src_sync (
    input wire logic mclk,
    input wire logic resetn,
    src_bus_if.sync bus
);
    logic [8:0] meta_q;
    logic [8:0] meta_d;
    logic [8:0] stab_q;
    logic [8:0] stab_d;
    always_comb begin
        meta_d = bus.srcRaw;
        stab_d = meta_q;
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_q <= 9'h000;
            stab_q <= 9'h000;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end
    assign bus.srcSync = stab_q;
endmodule

// file: src_reset_combiner.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
module src_reset_combiner (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic powerOnReset,
    input wire logic externalClearPinResetN,
    input wire logic softwareInstructionReset,
    input wire logic watchdogTimeoutReset,
    input wire logic brownoutReset,
    input wire logic configMismatchReset,
    input wire logic trapConflictReset,
    input wire logic illegalOpcodeReset,
    input wire logic uninitWregReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic masterSystemReset,
    output logic [8:0] resetCauseStatus
);
    src_bus_if bus ();
    logic [8:0] src;
    logic [8:0] srcPrev_q;
    logic [8:0] srcPrev_d;
    logic [8:0] status_q;
    logic [8:0] status_d;
    logic [31:0] scratch_q;
    logic [31:0] scratch_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic master_system_reset_q;
    logic master_system_reset_d;
    logic setup;
    logic wrStatus;
    logic wrScratch;
    logic mapped;
    logic [8:0] rise;

    function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Decode is shared by the write strobes, the error flag and the read mux
    function automatic logic isStatus(input logic [11:0] addr);
        return addr == src_pkg::ADDR_STATUS;
    endfunction

    function automatic logic isScratch(input logic [11:0] addr);
        return addr == src_pkg::ADDR_SCRATCH;
    endfunction

    // Byte lane 0 carries bits 7:0, lane 1 carries bit 8
    function automatic logic [8:0] statusMerge(input logic [8:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [8:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[8] = nw[8];
        end
        return r;
    endfunction

    always_comb begin
        bus.srcRaw = 9'h000;
        bus.srcRaw[src_pkg::BIT_POR] = powerOnReset;
        bus.srcRaw[src_pkg::BIT_BROWN] = brownoutReset;
        bus.srcRaw[src_pkg::BIT_PIN] = ~externalClearPinResetN;
        bus.srcRaw[src_pkg::BIT_INSTR] = softwareInstructionReset;
        bus.srcRaw[src_pkg::BIT_WDOG] = watchdogTimeoutReset;
        bus.srcRaw[src_pkg::BIT_CFG] = configMismatchReset;
        bus.srcRaw[src_pkg::BIT_TRAP] = trapConflictReset;
        bus.srcRaw[src_pkg::BIT_IOP] = illegalOpcodeReset;
        bus.srcRaw[src_pkg::BIT_WREG] = uninitWregReset;
    end

    src_sync u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .bus(bus)
    );

    assign src = bus.srcSync;
    assign setup = psel & ~penable;
    assign mapped = isStatus(paddr) | isScratch(paddr);
    assign wrStatus = psel & penable & pwrite & pready_q & isStatus(paddr);
    assign wrScratch = psel & penable & pwrite & pready_q & isScratch(paddr);
    assign rise = src & ~srcPrev_q;

    always_comb begin
        srcPrev_d = src;
        master_system_reset_d = |src;
    end

    // The output starts asserted, but is released on the first edge after resetn while the synchroniser still holds zeros
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            srcPrev_q <= 9'h000;
            master_system_reset_q <= 1'h1;
        end else begin
            srcPrev_q <= srcPrev_d;
            master_system_reset_q <= master_system_reset_d;
        end
    end

    always_comb begin
        status_d = wrStatus ? statusMerge(status_q, pwdata, pstrb) : status_q;
        // set on cause
        // Applied after the write so a clear never hides a fresh cause
        status_d = status_d | rise;
        if (src[src_pkg::BIT_POR]) begin
            status_d = src_pkg::STATUS_POR_VAL;
        end
    end

    // Status and scratch are not cleared by resetn: power-on defines status, scratch stays unknown until written
    always_ff @(posedge mclk) begin
        status_q <= status_d;
    end

    always_comb begin
        scratch_d = scratch_q;
        if (wrScratch) begin
            scratch_d = byteMerge(scratch_q, pwdata, pstrb);
        end
    end

    always_ff @(posedge mclk) begin
        scratch_q <= scratch_d;
    end

    always_comb begin
        // No wait state: setup, then access with pready
        pready_d = setup;
        pslverr_d = setup & ~mapped;
        prdata_d = 32'h00000000;
        if (setup && !pwrite) begin
            if (isStatus(paddr)) begin
                prdata_d = {23'h000000, status_q};
            end else if (isScratch(paddr)) begin
                prdata_d = scratch_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign masterSystemReset = master_system_reset_q;
    assign resetCauseStatus = status_q;
endmodule

// file: src_properties.sv
`timescale 1ns/1ns
module src_properties (input wire logic mclk,
    input wire logic resetn,
    input wire logic powerOnReset,
    input wire logic watchdogTimeoutReset,
    input wire logic psel,
    input wire logic pready,
    input wire logic masterSystemReset,
    input wire logic [8:0] resetCauseStatus);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_rdy_next: assert property ($rose(psel) |=> pready) else $error("no ready");
    a_rdy_idle: assert property (!psel |=> !pready) else $error("stray ready");
    a_rdy_once: assert property (pready |=> !pready) else $error("long ready");
    a_rdy_sel: assert property (pready |-> psel) else $error("ready unselected");
    a_por_val: assert property (powerOnReset [*5] |->
        resetCauseStatus == 9'h003) else $error("por value");
    a_por_mst: assert property ($rose(powerOnReset) |->
        ##[2:4] masterSystemReset) else $error("por late");
    a_wdog_flag: assert property (watchdogTimeoutReset [*5] |->
        resetCauseStatus[4]) else $error("watchdog flag");
    a_wdog_mst: assert property (watchdogTimeoutReset [*5] |->
        masterSystemReset) else $error("watchdog reset");
    cover property (pready);
    cover property (resetCauseStatus == 9'h0e0);
    cover property (masterSystemReset && !powerOnReset);
endmodule
bind src_reset_combiner src_properties src_properties_i (.*);

// file: src_source_model.sv
`timescale 1ns/1ns
module src_source_model (input wire logic mclk,
    input wire logic fire,
    input wire logic [8:0] sel,
    output logic [8:0] src);
    logic [2:0] cnt_q = 3'h0;
    logic [8:0] sel_q = 9'h0;
    // Seven cycles so the level outlives both synchroniser stages
    always @(posedge mclk) cnt_q <= fire ? 3'h7 : cnt_q - {2'h0, cnt_q != 3'h0};
    always @(posedge mclk) if (fire) sel_q <= sel;
    assign src = cnt_q != 3'h0 ? sel_q : 9'h0;
endmodule

// file: src_reset_combiner_tb_top.sv
`timescale 1ns/1ns
module src_reset_combiner_tb_top;
    logic mclk = 1'h0;
    logic resetn, psel, penable, pwrite, fire, pready, pslverr, masterSystemReset, er;
    logic [3:0] pstrb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] sel, src, resetCauseStatus;
    int badCount = 0, checked = 0;
    // Rows: source mask driven, then the status word it should leave
    localparam logic [17:0] ROWS [9] = '{{9'h001, 9'h003}, {9'h002, 9'h002},
        {9'h004, 9'h004}, {9'h008, 9'h008}, {9'h010, 9'h010}, {9'h020, 9'h020},
        {9'h040, 9'h040}, {9'h080, 9'h080}, {9'h100, 9'h100}};
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin badCount++; \
    $display("Error %s exp %h got %h", n, e, s); end end
    initial forever #25 mclk = ~mclk;
    src_source_model src_source_model_i (.mclk, .fire, .sel, .src);
    src_reset_combiner src_reset_combiner_i (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .masterSystemReset, .resetCauseStatus,
        .powerOnReset(src[0]), .brownoutReset(src[1]), .externalClearPinResetN(~src[2]),
        .softwareInstructionReset(src[3]), .watchdogTimeoutReset(src[4]),
        .configMismatchReset(src[5]), .trapConflictReset(src[6]),
        .illegalOpcodeReset(src[7]), .uninitWregReset(src[8]));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hf);
        @(posedge mclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, s};
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic hit(input logic [8:0] k);
        {fire, sel} <= {1'h1, k};
        @(posedge mclk);
        fire <= 1'h0;
        // Two sync stages and one register stage after the model raises the source
        repeat (4) @(posedge mclk);
        `CHK("master_system_reset on", 1'h1, masterSystemReset)
        repeat (8) @(posedge mclk);
    endtask
    task automatic endOfTest;
        $display("checked %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        badCount++;
        endOfTest();
    end
    initial begin
        {resetn, psel, penable, pwrite, fire, sel, paddr, pwdata, pstrb} = 62'h0;
        repeat (3) @(posedge mclk);
        resetn <= 1'h1;
        for (int i = 0; i < 9; i++) begin
            apb(1'h1, 12'h0, 32'h0);
            hit(ROWS[i][17:9]);
            apb(1'h0, 12'h0, 32'h0);
            `CHK("cause", {23'h0, ROWS[i][8:0]}, rd)
            `CHK("status", ROWS[i][8:0], resetCauseStatus)
            `CHK("okay", 1'h0, er)
        end
        apb(1'h1, 12'h0, 32'ha0);
        apb(1'h0, 12'h0, 32'h0);
        `CHK("set", 32'ha0, rd)
        `CHK("master_system_reset", 1'h0, masterSystemReset)
        apb(1'h1, 12'h4, 32'h5a5aa5a5);
        apb(1'h0, 12'h8, 32'h0);
        `CHK("slverr", 1'h1, er)
        `CHK("unmapped", 32'h0, rd)
        resetn <= 1'h0;
        repeat (3) @(posedge mclk);
        `CHK("rstout", 1'h1, masterSystemReset)
        resetn <= 1'h1;
        hit(9'h40);
        apb(1'h0, 12'h0, 32'h0);
        `CHK("sticky", 32'he0, rd)
        apb(1'h0, 12'h4, 32'h0);
        `CHK("scratch", 32'h5a5aa5a5, rd)
        apb(1'h1, 12'h0, 32'h100, 4'h2);
        apb(1'h0, 12'h0, 32'h0);
        `CHK("strobe", 32'h1e0, rd)
        hit(9'h1);
        apb(1'h0, 12'h0, 32'h0);
        `CHK("por", 32'h3, rd)
        endOfTest();
    end
endmodule
